// ==== rtl/fcs_sequencer.sv ====
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
module fcs_sequencer #(
  parameter logic [15:0] T_BYTE = fcs_pkg::T_BYTE_TICKS,
  parameter logic [15:0] T_BURST = fcs_pkg::T_BURST_TICKS,
  parameter logic [15:0] T_PAGE = fcs_pkg::T_PAGE_TICKS,
  parameter logic [15:0] T_MASS = fcs_pkg::T_MASS_TICKS,
  parameter logic [15:0] T_BLANK = fcs_pkg::T_BLANK_TICKS
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Flash array and pump
  output fcs_pkg::fcs_array_s flash_array,
  input wire logic array_erased,
  // Protection source and debug access
  input wire logic [7:0] nonvolatile_protection_byte,
  input wire logic dbg_prot_we,
  input wire logic [7:0] dbg_prot_data
);
  import fcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic ap_valid_reg, ap_valid_next;
  logic ap_write_reg, ap_write_next;
  logic [7:0] ap_addr_reg, ap_addr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [6:0] div_reg, div_next;
  logic div_loaded_reg, div_loaded_next;
  logic accerr_reg, accerr_next;
  logic pviol_reg, pviol_next;
  logic blank_reg, blank_next;
  fcs_cmd_s latch_reg, latch_next;
  logic [1:0] stage_reg, stage_next;
  logic buf_v_reg, buf_v_next;
  fcs_cmd_s buf_reg, buf_next;
  fcs_state_e state_reg, state_next;
  fcs_cmd_s cur_reg, cur_next;
  logic pump_reg, pump_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [2:0] pre_reg, pre_next;
  logic [DIV_MSB:0] dcnt_reg, dcnt_next;
  logic [7:0] prot_reg, prot_next;
  logic prot_ld_reg;
  logic pre_tick, fclk_tick;
  logic wr, wr_div, wr_stat, wr_cmd, wr_array, launch_req;
  logic cbef, ccf, seq_ok, prot_on, prot_hit, burst_hold, run_done;
  logic [15:0] last_unprot;

  // Stage codes of the three-step sequence
  localparam logic [1:0] STG_NONE = 2'h0;
  localparam logic [1:0] STG_ADDR = 2'h1;
  localparam logic [1:0] STG_CMD = 2'h2;

  function automatic logic code_valid(input logic [7:0] c);
    return c == CMD_BLANK || c == CMD_BYTE || c == CMD_BURST ||
      c == CMD_PAGE || c == CMD_MASS;
  endfunction : code_valid

  function automatic logic [CNT_W-1:0] std_ticks(input logic [7:0] c);
    case (c)
      CMD_BYTE, CMD_BURST: return T_BYTE;
      CMD_PAGE: return T_PAGE;
      CMD_MASS: return T_MASS;
      default: return T_BLANK;
    endcase
  endfunction : std_ticks

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, read data registered in address phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;
  assign wr = ap_valid_reg && ap_write_reg;
  assign wr_div = wr && ap_addr_reg == OFS_DIV;
  assign wr_stat = wr && ap_addr_reg == OFS_STAT;
  assign wr_cmd = wr && ap_addr_reg == OFS_CMD;
  assign wr_array = wr && ap_addr_reg == OFS_ARRAY;
  assign launch_req = wr_stat && hwdata[STAT_CBEF];

  // Address phase capture and read mux; unmapped words read zero
  always_comb begin
    ap_valid_next = hsel && hready && htrans[1];
    ap_write_next = hwrite;
    ap_addr_next = haddr[7:0];
    rdata_next = rdata_reg;
    if (ap_valid_next && !hwrite) begin
      rdata_next = 32'h0000_0000;
      case (haddr[7:0])
        OFS_DIV: rdata_next[7:0] = {div_loaded_reg, div_reg};
        OFS_STAT: begin
          rdata_next[STAT_CBEF] = cbef;
          rdata_next[STAT_CCF] = ccf;
          rdata_next[STAT_PVIOL] = pviol_reg;
          rdata_next[STAT_ACCERR] = accerr_reg;
          rdata_next[STAT_BLANK] = blank_reg;
        end
        OFS_CMD: rdata_next[7:0] = latch_reg.code;
        OFS_PROT: rdata_next[7:0] = prot_reg;
        OFS_ARRAY: rdata_next[ARR_DATA_MSB:0] = {latch_reg.data, latch_reg.addr};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_addr_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ap_valid_reg <= ap_valid_next;
      ap_write_reg <= ap_write_next;
      ap_addr_reg <= ap_addr_next;
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescale and divide
  always_comb begin
    pre_next = pre_reg;
    dcnt_next = dcnt_reg;
    fclk_tick = 1'b0;
    pre_tick = !div_reg[PRESCALE_BIT] || pre_reg == PRE_LAST;
    // Held still until the divisor is valid
    if (div_loaded_reg) begin
      pre_next = pre_tick ? 3'h0 : pre_reg + 3'h1;
      if (pre_tick) begin
        if (dcnt_reg == div_reg[DIV_MSB:0]) begin
          dcnt_next = '0;
          fclk_tick = 1'b1;
        end else begin
          dcnt_next = dcnt_reg + 6'h01;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_reg <= 3'h0;
      dcnt_reg <= '0;
    end else begin
      pre_reg <= pre_next;
      dcnt_reg <= dcnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and protection decode
  // empty only when buffer slot free
  assign cbef = !buf_v_reg;
  // complete when idle and nothing queued
  assign ccf = state_reg == ST_IDLE && !buf_v_reg;
  assign seq_ok = !accerr_reg && !pviol_reg;
  assign prot_on = !prot_reg[PROT_DIS_BIT];
  assign last_unprot = {prot_reg[7:1], PAGE_ONES};
  // region above boundary, nonvolatile byte included
  assign prot_hit = prot_on && (latch_reg.code == CMD_MASS ||
    (latch_reg.code != CMD_BLANK && latch_reg.addr > last_unprot));
  assign burst_hold = cur_reg.code == CMD_BURST && buf_v_reg &&
    buf_reg.code == CMD_BURST && buf_reg.addr == cur_reg.addr + 16'h0001 &&
    buf_reg.addr[ROW_MSB:0] != '0;
  assign run_done = state_reg == ST_RUN && fclk_tick && cnt_reg <= 16'h0001;

  assign flash_array = '{pump_on: pump_reg, active: state_reg == ST_RUN,
    code: cur_reg.code, addr: cur_reg.addr, data: cur_reg.data};

  ////////////////////////////////////////////////////////////////////////////
  // Register file and command engine
  always_comb begin
    div_next = div_reg;
    div_loaded_next = div_loaded_reg;
    accerr_next = accerr_reg;
    pviol_next = pviol_reg;
    blank_next = blank_reg;
    latch_next = latch_reg;
    stage_next = stage_reg;
    buf_v_next = buf_v_reg;
    buf_next = buf_reg;
    state_next = state_reg;
    cur_next = cur_reg;
    pump_next = pump_reg;
    cnt_next = cnt_reg;
    prot_next = prot_reg;
    // load once after reset, then debug port only
    if (!prot_ld_reg) begin
      prot_next = nonvolatile_protection_byte;
    end else if (dbg_prot_we) begin
      prot_next = dbg_prot_data;
    end
    // Clears come first so a same-cycle error wins
    if (wr_stat && hwdata[STAT_PVIOL]) pviol_next = 1'b0;
    if (wr_stat && hwdata[STAT_ACCERR]) accerr_next = 1'b0;
    // single write, blocked during access error
    if (wr_div && !accerr_reg && !div_loaded_reg) begin
      div_next = hwdata[6:0];
      div_loaded_next = 1'b1;
    end
    case (state_reg)
      ST_IDLE: begin
        // pump back on for a fresh command other than a blank check
        if (buf_v_reg) begin
          cur_next = buf_reg;
          buf_v_next = 1'b0;
          state_next = ST_RUN;
          pump_next = buf_reg.code != CMD_BLANK;
          cnt_next = std_ticks(buf_reg.code);
        end
      end
      ST_RUN: begin
        if (fclk_tick && !run_done) begin
          cnt_next = cnt_reg - 16'h0001;
        end else if (run_done) begin
          if (cur_reg.code == CMD_BLANK) blank_next = array_erased;
          if (burst_hold) begin
            cur_next = buf_reg;
            buf_v_next = 1'b0;
            cnt_next = T_BURST;
          // pump off, one idle cycle before next
          end else begin
            state_next = ST_IDLE;
            pump_next = 1'b0;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
    // Sequence writes only while no error is pending
    if (seq_ok) begin
      if (wr_array) begin
        if (stage_reg == STG_NONE && cbef) begin
          latch_next.addr = hwdata[15:0];
          latch_next.data = hwdata[ARR_DATA_MSB:ARR_DATA_LSB];
          stage_next = STG_ADDR;
        end else begin
          accerr_next = 1'b1;
          stage_next = STG_NONE;
        end
      end
      if (wr_cmd) begin
        if (stage_reg == STG_ADDR && code_valid(hwdata[7:0])) begin
          latch_next.code = hwdata[7:0];
          stage_next = STG_CMD;
        end else begin
          accerr_next = 1'b1;
          stage_next = STG_NONE;
        end
      end
      if (launch_req) begin
        stage_next = STG_NONE;
        if (stage_reg != STG_CMD || !cbef || !div_loaded_reg) begin
          accerr_next = 1'b1;
        end else if (prot_hit) begin
          pviol_next = 1'b1;
        end else begin
          buf_v_next = 1'b1;
          buf_next = latch_reg;
          if (latch_reg.code == CMD_PAGE) begin
            buf_next.addr[PAGE_LSB-1:0] = '0;
          end
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= 7'h00;
      div_loaded_reg <= 1'b0;
      accerr_reg <= 1'b0;
      pviol_reg <= 1'b0;
      blank_reg <= 1'b0;
      latch_reg <= '0;
      stage_reg <= STG_NONE;
      buf_v_reg <= 1'b0;
      buf_reg <= '0;
      state_reg <= ST_IDLE;
      cur_reg <= '0;
      pump_reg <= 1'b0;
      cnt_reg <= '0;
      prot_reg <= PROT_RESET;
      prot_ld_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      div_loaded_reg <= div_loaded_next;
      accerr_reg <= accerr_next;
      pviol_reg <= pviol_next;
      blank_reg <= blank_next;
      latch_reg <= latch_next;
      stage_reg <= stage_next;
      buf_v_reg <= buf_v_next;
      buf_reg <= buf_next;
      state_reg <= state_next;
      cur_reg <= cur_next;
      pump_reg <= pump_next;
      cnt_reg <= cnt_next;
      prot_reg <= prot_next;
      prot_ld_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_launch_ok;
    launch_req && seq_ok && stage_reg == STG_CMD && cbef && div_loaded_reg && !prot_hit;
  endsequence
  sequence s_row_break;
    run_done && cur_reg.code == CMD_BURST && buf_v_reg &&
      buf_reg.code == CMD_BURST && buf_reg.addr[ROW_MSB:0] == '0;
  endsequence

  property p_div_once;
    div_loaded_reg && $past(div_loaded_reg) |-> $stable(div_reg);
  endproperty
  a_div_once: assert property (p_div_once) else $error("divider changed twice");
  property p_div_err;
    wr_div && accerr_reg && !div_loaded_reg |=> !div_loaded_reg;
  endproperty
  a_div_err: assert property (p_div_err) else $error("divider taken under error");
  property p_bad_code;
    wr_cmd && seq_ok && !code_valid(hwdata[7:0]) |=> accerr_reg && stage_reg == STG_NONE;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("bad code accepted");
  property p_launch;
    s_launch_ok |=> !cbef && !ccf ##1 state_reg == ST_RUN || buf_v_reg;
  endproperty
  a_launch: assert property (p_launch) else $error("launch not taken");
  property p_reject;
    launch_req && seq_ok && stage_reg == STG_CMD && cbef && div_loaded_reg && prot_hit
      |=> pviol_reg && cbef;
  endproperty
  a_reject: assert property (p_reject) else $error("protected command ran");
  property p_pump_off;
    run_done && !buf_v_reg && !launch_req |=> !pump_reg && state_reg == ST_IDLE && ccf;
  endproperty
  a_pump_off: assert property (p_pump_off) else $error("pump left on");
  property p_burst_time;
    run_done && burst_hold |=> pump_reg && cnt_reg == T_BURST;
  endproperty
  a_burst_time: assert property (p_burst_time) else $error("burst time wrong");
  property p_row_break;
    s_row_break |=> !pump_reg ##1 pump_reg && cnt_reg == T_BYTE;
  endproperty
  a_row_break: assert property (p_row_break) else $error("row change kept pump");
  property p_prot_sw;
    wr && ap_addr_reg == OFS_PROT && !dbg_prot_we && prot_ld_reg |=> $stable(prot_reg);
  endproperty
  a_prot_sw: assert property (p_prot_sw) else $error("software changed protection");
endmodule : fcs_sequencer

// ==== rtl/fcs_pkg.sv ====
package fcs_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_DIV = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_PROT = 8'h0C;
  localparam logic [7:0] OFS_ARRAY = 8'h10;
  // Divider register fields
  localparam int DIV_LOADED_BIT = 7;
  localparam int PRESCALE_BIT = 6;
  localparam int DIV_MSB = 5;
  localparam logic [2:0] PRE_LAST = 3'h7;
  // Status register fields
  localparam int STAT_CBEF = 7;
  localparam int STAT_CCF = 6;
  localparam int STAT_PVIOL = 5;
  localparam int STAT_ACCERR = 4;
  localparam int STAT_BLANK = 2;
  // Array write word: address low, data above it
  localparam int ARR_DATA_LSB = 16;
  localparam int ARR_DATA_MSB = 23;
  // Geometry
  localparam int ROW_MSB = 5;
  localparam int PAGE_LSB = 9;
  localparam int PROT_DIS_BIT = 0;
  localparam logic [8:0] PAGE_ONES = 9'h1FF;
  localparam logic [7:0] PROT_RESET = 8'hFF;
  // Command codes
  localparam logic [7:0] CMD_BLANK = 8'h05;
  localparam logic [7:0] CMD_BYTE = 8'h20;
  localparam logic [7:0] CMD_BURST = 8'h25;
  localparam logic [7:0] CMD_PAGE = 8'h40;
  localparam logic [7:0] CMD_MASS = 8'h41;
  // Operation lengths in timing-clock pulses
  localparam int CNT_W = 16;
  localparam logic [15:0] T_BYTE_TICKS = 16'h0009;
  localparam logic [15:0] T_BURST_TICKS = 16'h0004;
  localparam logic [15:0] T_PAGE_TICKS = 16'h0FA0;
  localparam logic [15:0] T_MASS_TICKS = 16'h4E20;
  localparam logic [15:0] T_BLANK_TICKS = 16'h0010;

  typedef struct packed {
    logic [7:0] code;
    logic [15:0] addr;
    logic [7:0] data;
  } fcs_cmd_s;

  typedef struct packed {
    logic pump_on;
    logic active;
    logic [7:0] code;
    logic [15:0] addr;
    logic [7:0] data;
  } fcs_array_s;

  typedef enum logic {ST_IDLE, ST_RUN} fcs_state_e;
endpackage : fcs_pkg

// ==== sim/fcs_flash_model.sv ====
module fcs_flash_model (
  // Clock
  input wire logic hclk,
  // Control from the sequencer
  input fcs_pkg::fcs_array_s flash_array,
  // Blank result back to the sequencer
  output logic array_erased
);
  timeunit 1ns;
  timeprecision 1ns;
  import fcs_pkg::*;

  fcs_array_s seg_head[$];
  int seg_len[$];
  int pump_falls;
  fcs_array_s cur;
  int cur_len;
  logic in_seg;
  logic prev_pump;

  initial begin
    array_erased = 1'b0;
    pump_falls = 0;
    cur_len = 0;
    in_seg = 1'b0;
    prev_pump = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One record per addressed operation; a held pump keeps active high,
  // so an address change also closes a record
  always @(posedge hclk) begin
    if (in_seg && (!flash_array.active || flash_array.addr != cur.addr)) begin
      seg_head.push_back(cur);
      seg_len.push_back(cur_len);
      in_seg = 1'b0;
    end
    if (flash_array.active && in_seg) begin
      cur_len++;
    end else if (flash_array.active) begin
      cur = flash_array;
      cur_len = 1;
      in_seg = 1'b1;
      // Array is blank after mass erase, dirty after any program
      if (flash_array.code == CMD_MASS) array_erased <= 1'b1;
      if (flash_array.code == CMD_BYTE || flash_array.code == CMD_BURST) array_erased <= 1'b0;
    end
    // Count every high-voltage shutdown
    if (prev_pump && !flash_array.pump_on) pump_falls++;
    prev_pump = flash_array.pump_on;
  end
endmodule : fcs_flash_model

// ==== sim/test_flash_command_sequencer.sv ====
module test_flash_command_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  import fcs_pkg::*;

  // Short operation lengths keep the run brief; burst slots leave room to queue
  localparam logic [15:0] TB = 16'h0014;
  localparam logic [15:0] TU = 16'h000C;
  localparam logic [15:0] TP = 16'h0014;
  localparam logic [15:0] TM = 16'h0028;
  localparam logic [15:0] TK = 16'h0004;

  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] nonvolatile_protection_byte = 8'hDE;
  logic dbg_prot_we = 1'b0;
  logic [7:0] dbg_prot_data = 8'h00;
  wire [31:0] hrdata;
  wire hreadyout;
  wire hresp;
  wire fcs_array_s flash_array;
  wire array_erased;
  int err_total = 0;
  int checks = 0;
  logic [31:0] rd;

  always #50 hclk = ~hclk;

  fcs_sequencer #(.T_BYTE(TB), .T_BURST(TU), .T_PAGE(TP), .T_MASS(TM), .T_BLANK(TK)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .flash_array(flash_array),
    .array_erased(array_erased), .nonvolatile_protection_byte(nonvolatile_protection_byte),
    .dbg_prot_we(dbg_prot_we),
    .dbg_prot_data(dbg_prot_data));

  fcs_flash_model fm (.hclk(hclk), .flash_array(flash_array), .array_erased(array_erased));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison
  task automatic close_out;
    if (err_total == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////////
  // Bus master; every call starts just after a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (hreadyout !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: bus ready timeout", $time);
      close_out();
    end
  endtask : wait_rdy

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd & m, e);
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask : rdchk

  // Three-step launch: array write, command code, write one to empty flag
  task automatic launch(input logic [15:0] a, input logic [7:0] d, input logic [7:0] c);
    bus(1'b1, OFS_ARRAY, {8'h00, d, a});
    bus(1'b1, OFS_CMD, {24'h00_0000, c});
    bus(1'b1, OFS_STAT, 32'h0000_0080);
  endtask : launch

  // Polling is bounded; a stuck flag ends the run
  task automatic wait_bit(input int b);
    int n;
    n = 0;
    do begin
      bus(1'b0, OFS_STAT, 32'h0000_0000);
      n++;
    end while (rd[b] !== 1'b1 && n < 2000);
    if (rd[b] !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: status flag timeout", $time);
      close_out();
    end
  endtask : wait_bit

  task automatic seg_chk(input int i, input logic [15:0] len, input logic [7:0] code,
      input logic [15:0] a, input logic [15:0] am, input logic pump);
    chk(32'(fm.seg_len.size() > i), 32'h0000_0001);
    if (fm.seg_len.size() > i) begin
      chk(32'(fm.seg_len[i]), {16'h0000, len});
      chk({24'h00_0000, fm.seg_head[i].code}, {24'h00_0000, code});
      chk({16'h0000, fm.seg_head[i].addr & am}, {16'h0000, a});
      chk({31'h0, fm.seg_head[i].pump_on}, {31'h0, pump});
    end
  endtask : seg_chk

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic s_reset;
    rdchk(OFS_PROT, 32'h0000_00FF, 32'h0000_00DE);
    rdchk(OFS_DIV, 32'hFFFF_FFFF, 32'h0000_0000);
    rdchk(OFS_STAT, 32'h0000_00F0, 32'h0000_00C0);
    bus(1'b1, 8'h20, 32'h0000_00FF);
    rdchk(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
  endtask : s_reset

  task automatic s_unloaded;
    launch(16'h1870, 8'h11, CMD_BYTE);
    rdchk(OFS_STAT, 32'h0000_00F0, 32'h0000_00D0);
    bus(1'b1, OFS_DIV, 32'h0000_0000);
    rdchk(OFS_DIV, 32'h0000_00FF, 32'h0000_0000);
    bus(1'b1, OFS_STAT, 32'h0000_0010);
    rdchk(OFS_STAT, 32'h0000_00F0, 32'h0000_00C0);
    chk(32'(fm.seg_len.size()), 32'h0000_0000);
  endtask : s_unloaded

  task automatic s_divider;
    bus(1'b1, OFS_DIV, 32'h0000_0000);
    rdchk(OFS_DIV, 32'h0000_00FF, 32'h0000_0080);
    bus(1'b1, OFS_DIV, 32'h0000_007F);
    rdchk(OFS_DIV, 32'h0000_00FF, 32'h0000_0080);
  endtask : s_divider

  task automatic s_program;
    launch(16'hDFFF, 8'hA5, CMD_BYTE);
    wait_bit(STAT_CCF);
    seg_chk(0, TB, CMD_BYTE, 16'hDFFF, 16'hFFFF, 1'b1);
    chk({24'h00_0000, fm.seg_head[0].data}, 32'h0000_00A5);
    chk(32'(fm.pump_falls), 32'h0000_0001);
    rdchk(OFS_STAT, 32'h0000_00F0, 32'h0000_00C0);
  endtask : s_program

  task automatic s_protect;
    launch(16'hE000, 8'h00, CMD_BYTE);
    rdchk(OFS_STAT, 32'h0000_00F0, 32'h0000_00E0);
    bus(1'b1, OFS_STAT, 32'h0000_0020);
    bus(1'b1, OFS_PROT, 32'h0000_00FF);
    rdchk(OFS_PROT, 32'h0000_00FF, 32'h0000_00DE);
    launch(16'h1870, 8'h00, CMD_MASS);
    rdchk(OFS_STAT, 32'h0000_00F0, 32'h0000_00E0);
    bus(1'b1, OFS_STAT, 32'h0000_0020);
    chk(32'(fm.seg_len.size()), 32'h0000_0001);
    dbg_prot_data <= 8'hFF;
    dbg_prot_we <= 1'b1;
    @(posedge hclk);
    dbg_prot_we <= 1'b0;
    rdchk(OFS_PROT, 32'h0000_00FF, 32'h0000_00FF);
  endtask : s_protect

  task automatic s_erase;
    // page erase aligned, then mass erase and blank check
    launch(16'h1A37, 8'h77, CMD_PAGE);
    wait_bit(STAT_CCF);
    seg_chk(1, TP, CMD_PAGE, 16'h1A00, 16'hFFFF, 1'b1);
    launch(16'h4321, 8'h00, CMD_MASS);
    wait_bit(STAT_CCF);
    seg_chk(2, TM, CMD_MASS, 16'h0000, 16'h0000, 1'b1);
    launch(16'h0123, 8'hC3, CMD_BLANK);
    wait_bit(STAT_CCF);
    seg_chk(3, TK, CMD_BLANK, 16'h0000, 16'h0000, 1'b0);
    rdchk(OFS_STAT, 32'h0000_00F4, 32'h0000_00C4);
    launch(16'h1870, 8'h00, 8'h30);
    rdchk(OFS_STAT, 32'h0000_00F0, 32'h0000_00D0);
    bus(1'b1, OFS_STAT, 32'h0000_0010);
    chk(32'(fm.seg_len.size()), 32'h0000_0004);
  endtask : s_erase

  task automatic s_burst;
    int base;
    // queued bursts across one row boundary
    base = fm.pump_falls;
    launch(16'h7FFE, 8'h01, CMD_BURST);
    wait_bit(STAT_CBEF);
    launch(16'h7FFF, 8'h02, CMD_BURST);
    wait_bit(STAT_CBEF);
    launch(16'h8000, 8'h03, CMD_BURST);
    wait_bit(STAT_CCF);
    seg_chk(4, TB, CMD_BURST, 16'h7FFE, 16'hFFFF, 1'b1);
    seg_chk(5, TU, CMD_BURST, 16'h7FFF, 16'hFFFF, 1'b1);
    seg_chk(6, TB, CMD_BURST, 16'h8000, 16'hFFFF, 1'b1);
    chk(32'(fm.pump_falls - base), 32'h0000_0002);
  endtask : s_burst

  task automatic s_prescale;
    int n;
    // mid-run reset, then prescale by eight with divisor one
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(OFS_DIV, 32'hFFFF_FFFF, 32'h0000_0000);
    rdchk(OFS_PROT, 32'h0000_00FF, 32'h0000_00DE);
    bus(1'b1, OFS_DIV, 32'h0000_0041);
    rdchk(OFS_DIV, 32'h0000_00FF, 32'h0000_00C1);
    launch(16'h0040, 8'h00, CMD_BLANK);
    wait_bit(STAT_CCF);
    n = fm.seg_len.size();
    chk(32'(n), 32'h0000_0008);
    // Pulse phase is free-running, so the length falls in one pulse window
    if (n > 7) begin
      chk(32'(fm.seg_len[7] > (int'(TK) - 1) * 16 && fm.seg_len[7] <= int'(TK) * 16), 32'h0000_0001);
    end
  endtask : s_prescale

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    s_reset();
    s_unloaded();
    s_divider();
    s_program();
    s_protect();
    s_erase();
    s_burst();
    s_prescale();
    close_out();
  end
endmodule : test_flash_command_sequencer
